// ### rtl/pm_msi_pkg.sv
// package: register map, field layout, reset values and carrier types
package pm_msi_pkg;
  localparam logic [11:0] pm_ctrl_off = 12'h0c4;
  localparam logic [11:0] msi_ctrl_off = 12'h0d0;
  localparam logic [11:0] msi_addr_low_off = 12'h0d4;
  localparam logic [11:0] msi_addr_high_off = 12'h0d8;
  localparam logic [11:0] msidata_off = 12'h0dc;
  localparam int power_state_lsb = 0;
  localparam int keep_bit = 3;
  localparam int wake_en_bit = 8;
  localparam int wake_flag_bit = 15;
  localparam int msi_en_bit = 16;
  localparam int msg_count_enable_lsb = 20;
  localparam int wide_bit = 23;
  localparam logic [1:0] power_d0 = 2'h0;
  localparam logic [1:0] power_d3hot = 2'h3;
  localparam logic [1:0] power_state_reset = 2'h0;
  localparam logic keep_reset = 1'b1;
  localparam logic [7:0] msi_cap_code = 8'h05;
  localparam logic [7:0] next_ptr_reset = 8'h00;
  localparam logic [2:0] msg_count_single = 3'h0;
  localparam logic [2:0] mmc_value = 3'h0;
  localparam logic wide_capable = 1'b1;
  localparam logic [31:0] addr_low_mask = 32'hffff_fffc;
  localparam logic [31:0] data_mask = 32'h0000_ffff;
  localparam logic [31:0] bus_zero = 32'h0000_0000;

  // one MSI memory write toward the upstream port
  typedef struct packed {
    logic wide;
    logic [31:0] addr_high;
    logic [31:0] addr_low;
    logic [31:0] payload;
  } msi_write_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : pm_msi_pkg

// ### rtl/pm_and_msi_capability_regs.sv
// module: power management control/status and MSI capability registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

// Functional notes
// R1 - two-bit power state field, D0 is 0, D3hot is 3, resets to D0
// R2 - codes for D1 and D2 are unsupported; writes of them are ignored
// R3 - context keep flag resets to 1; when 0 D3hot-to-D0 resets state
// R4 - wake messages generated only while sticky wake enable is set; resets to 0
// R5 - hot reset leaves wake enable untouched
// R6 - initialisation should set wake enable when D3cold hot-plug wakeup wanted
// R7 - wake event flag sets on own wake event even if enable clear; W1C
// R8 - forwarded wake messages never set the wake event flag
// R9 - upstream port never sets the wake event flag
// R10 - data select, data scale and data byte read zero
// R11 - bus power support and clock control enable read zero
// R12 - capability code 5, next pointer resets to 0
// R13 - MSI enable bit at 16, read/write, resets to 0
// R14 - one message only: count enable hardwired, capable field reads 0
// R15 - wide address capable reads 1; 64-bit writes possible
// R16 - low address bits 31:2 stored, bits 1:0 read zero
// R17 - upper address nonzero gives 64-bit write, else 32-bit
// R18 - every MSI write routes to the upstream port
// R19 - software must program MSI addresses that route upstream
// R20 - message data 16 bits form low data half; 31:16 reserved
// R21 - MSI write only while enabled; upper data half driven zero
module pm_and_msi_capability_regs #(
  parameter logic is_upstream = 1'b0
) (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hot_reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port events
  input wire logic own_wake_event,
  input wire logic forwarded_wake,
  input wire logic msi_request,
  // outputs toward the switch core
  output logic wake_msg_send,
  output logic context_reset,
  output logic [1:0] power_state_field,
  output logic msi_valid,
  output logic msi_to_upstream,
  output pm_msi_pkg::msi_write_t msi_write
);

  pm_msi_pkg::apb_req_t req;
  logic wr_en;
  logic rd_en;
  logic context_keep_flag;
  logic wake_msg_enable;
  logic wake_event_flag;
  logic msi_enable;
  logic [7:0] next_capability_pointer;
  logic [31:0] msi_address_low;
  logic [31:0] upper_msg_address;
  logic [15:0] msg_payload;
  logic [31:0] next_prdata;
  logic hit;

  assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
  assign wr_en = psel && penable && req.pwrite;
  assign rd_en = psel && penable && !req.pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  function automatic logic is_hit(input logic [11:0] a);
    is_hit = (a == pm_msi_pkg::pm_ctrl_off) || (a == pm_msi_pkg::msi_ctrl_off) ||
      (a == pm_msi_pkg::msi_addr_low_off) || (a == pm_msi_pkg::msi_addr_high_off) ||
      (a == pm_msi_pkg::msidata_off);
  endfunction : is_hit

  assign hit = is_hit(req.paddr);

  // power state and context keep (ordinary reset domain, also hot reset)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state_field <= pm_msi_pkg::power_state_reset;
      context_keep_flag <= pm_msi_pkg::keep_reset;
      context_reset <= 1'b0;
    end else if (hot_reset) begin
      power_state_field <= pm_msi_pkg::power_state_reset;
      context_keep_flag <= pm_msi_pkg::keep_reset;
      context_reset <= 1'b0;
    end else begin
      context_reset <= 1'b0;
      if (wr_en && req.paddr == pm_msi_pkg::pm_ctrl_off) begin
        // R1 state write
        // R2 reserved codes dropped
        if (req.pwdata[pm_msi_pkg::power_state_lsb +: 2] == pm_msi_pkg::power_d0 ||
            req.pwdata[pm_msi_pkg::power_state_lsb +: 2] == pm_msi_pkg::power_d3hot) begin
          power_state_field <= req.pwdata[pm_msi_pkg::power_state_lsb +: 2];
          // R3 context loss pulse
          context_reset <= (power_state_field == pm_msi_pkg::power_d3hot) &&
            (req.pwdata[pm_msi_pkg::power_state_lsb +: 2] == pm_msi_pkg::power_d0) &&
            !context_keep_flag;
        end
        context_keep_flag <= req.pwdata[pm_msi_pkg::keep_bit];
      end
    end
  end

  // sticky wake bits: of the two resets only presetn clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_msg_enable <= 1'b0;
    end else if (wr_en && req.paddr == pm_msi_pkg::pm_ctrl_off) begin
      // R5 sticky enable
      wake_msg_enable <= req.pwdata[pm_msi_pkg::wake_en_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_flag <= 1'b0;
    end else if (own_wake_event && !is_upstream) begin
      // R7 own event sets, set wins
      // R9 never upstream
      wake_event_flag <= 1'b1;
    end else if (wr_en && req.paddr == pm_msi_pkg::pm_ctrl_off &&
                 req.pwdata[pm_msi_pkg::wake_flag_bit]) begin
      wake_event_flag <= 1'b0;
    end
  end

  // R4 gated wake message
  // R8 forwarded wake does not touch flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_msg_send <= 1'b0;
    end else begin
      wake_msg_send <= (own_wake_event && !is_upstream && wake_msg_enable) || forwarded_wake;
    end
  end

  // MSI registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msi_enable <= 1'b0;
      next_capability_pointer <= pm_msi_pkg::next_ptr_reset;
      msi_address_low <= pm_msi_pkg::bus_zero;
      upper_msg_address <= pm_msi_pkg::bus_zero;
      msg_payload <= 16'h0000;
    end else if (hot_reset) begin
      msi_enable <= 1'b0;
      next_capability_pointer <= pm_msi_pkg::next_ptr_reset;
      msi_address_low <= pm_msi_pkg::bus_zero;
      upper_msg_address <= pm_msi_pkg::bus_zero;
      msg_payload <= 16'h0000;
    end else if (wr_en) begin
      case (req.paddr)
        pm_msi_pkg::msi_ctrl_off: begin
          // R13 enable write
          msi_enable <= req.pwdata[pm_msi_pkg::msi_en_bit];
        end
        pm_msi_pkg::msi_addr_low_off: begin
          // R16 dword aligned
          msi_address_low <= req.pwdata & pm_msi_pkg::addr_low_mask;
        end
        pm_msi_pkg::msi_addr_high_off: begin
          upper_msg_address <= req.pwdata;
        end
        pm_msi_pkg::msidata_off: begin
          // R20 low half kept
          msg_payload <= req.pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    next_prdata = pm_msi_pkg::bus_zero;
    case (req.paddr)
      pm_msi_pkg::pm_ctrl_off: begin
        // R10 power data fields zero
        // R11 bus power bits zero
        next_prdata[pm_msi_pkg::power_state_lsb +: 2] = power_state_field;
        next_prdata[pm_msi_pkg::keep_bit] = context_keep_flag;
        next_prdata[pm_msi_pkg::wake_en_bit] = wake_msg_enable;
        next_prdata[pm_msi_pkg::wake_flag_bit] = wake_event_flag;
      end
      pm_msi_pkg::msi_ctrl_off: begin
        // R12 capability code
        // R14 single message
        // R15 wide capable
        next_prdata[7:0] = pm_msi_pkg::msi_cap_code;
        next_prdata[15:8] = next_capability_pointer;
        next_prdata[pm_msi_pkg::msi_en_bit] = msi_enable;
        next_prdata[19:17] = pm_msi_pkg::mmc_value;
        next_prdata[pm_msi_pkg::msg_count_enable_lsb +: 3] = pm_msi_pkg::msg_count_single;
        next_prdata[pm_msi_pkg::wide_bit] = pm_msi_pkg::wide_capable;
      end
      pm_msi_pkg::msi_addr_low_off: next_prdata = msi_address_low;
      pm_msi_pkg::msi_addr_high_off: next_prdata = upper_msg_address;
      pm_msi_pkg::msidata_off: next_prdata = {16'h0000, msg_payload};
      default: next_prdata = pm_msi_pkg::bus_zero;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= pm_msi_pkg::bus_zero;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // MSI write generation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msi_valid <= 1'b0;
      msi_to_upstream <= 1'b0;
      msi_write <= '0;
    end else begin
      // R21 only while enabled
      msi_valid <= msi_request && msi_enable;
      // R18 route upstream
      msi_to_upstream <= msi_request && msi_enable;
      if (msi_request && msi_enable) begin
        // R17 width by upper address
        msi_write.wide <= (upper_msg_address != pm_msi_pkg::bus_zero);
        msi_write.addr_high <= upper_msg_address;
        msi_write.addr_low <= msi_address_low;
        // R21 upper data zero
        msi_write.payload <= {16'h0000, msg_payload};
      end
    end
  end

  // assertions
  property p_wake_set;
    @(posedge pclk) disable iff (!presetn)
      (own_wake_event && !is_upstream) |=> wake_event_flag;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set"); // R7

  property p_fwd_no_set;
    @(posedge pclk) disable iff (!presetn)
      (!wake_event_flag && !own_wake_event) |=> !wake_event_flag;
  endproperty
  a_fwd_no_set: assert property (p_fwd_no_set) else $error("wake flag set spuriously"); // R8

  property p_upstream_never;
    @(posedge pclk) disable iff (!presetn) is_upstream |-> !wake_event_flag;
  endproperty
  a_upstream_never: assert property (p_upstream_never) else $error("upstream wake flag"); // R9

  property p_power_state_field_legal;
    @(posedge pclk) disable iff (!presetn)
      power_state_field == pm_msi_pkg::power_d0 || power_state_field == pm_msi_pkg::power_d3hot;
  endproperty
  a_power_state_field_legal: assert property (p_power_state_field_legal) else $error("reserved power state"); // R2

  property p_hot_keeps_enable;
    @(posedge pclk) disable iff (!presetn)
      (hot_reset && !wr_en) |=> $stable(wake_msg_enable);
  endproperty
  a_hot_keeps_enable: assert property (p_hot_keeps_enable) else $error("enable lost"); // R5

  property p_wake_gate;
    @(posedge pclk) disable iff (!presetn)
      (own_wake_event && !forwarded_wake && !wake_msg_enable) |=> !wake_msg_send;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake msg while disabled"); // R4

  property p_msi_gate;
    @(posedge pclk) disable iff (!presetn)
      msi_valid |-> $past(msi_enable) && msi_to_upstream && msi_write.payload[31:16] == 16'h0000;
  endproperty
  a_msi_gate: assert property (p_msi_gate) else $error("msi while disabled"); // R21

  property p_msi_wide;
    @(posedge pclk) disable iff (!presetn)
      msi_valid |-> msi_write.wide == (msi_write.addr_high != pm_msi_pkg::bus_zero);
  endproperty
  a_msi_wide: assert property (p_msi_wide) else $error("msi width wrong"); // R17

  property p_addr_align;
    @(posedge pclk) disable iff (!presetn) msi_address_low[1:0] == 2'h0;
  endproperty
  a_addr_align: assert property (p_addr_align) else $error("address low bits set"); // R16

  sequence s_cap_read;
    psel && !penable && !pwrite && paddr == pm_msi_pkg::msi_ctrl_off;
  endsequence
  property p_cap_read;
    @(posedge pclk) disable iff (!presetn)
      s_cap_read |=> prdata[7:0] == pm_msi_pkg::msi_cap_code && prdata[23] && prdata[22:17] == 6'h00;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability word wrong"); // R12

  sequence s_pm_write;
    psel && penable && pwrite && paddr == pm_msi_pkg::pm_ctrl_off && !hot_reset;
  endsequence

  sequence s_pm_read;
    psel && !penable && !pwrite && paddr == pm_msi_pkg::pm_ctrl_off;
  endsequence

  sequence s_cap_write;
    psel && penable && pwrite && paddr == pm_msi_pkg::msi_ctrl_off && !hot_reset;
  endsequence

  property p_state_d3;
    @(posedge pclk) disable iff (!presetn)
      s_pm_write ##0 (pwdata[1:0] == pm_msi_pkg::power_d3hot) |=>
        power_state_field == pm_msi_pkg::power_d3hot;
  endproperty
  a_state_d3: assert property (p_state_d3) else $error("power state write lost"); // R1

  property p_state_reserved;
    @(posedge pclk) disable iff (!presetn)
      s_pm_write ##0 (pwdata[1:0] != pm_msi_pkg::power_d0 &&
        pwdata[1:0] != pm_msi_pkg::power_d3hot) |=> $stable(power_state_field);
  endproperty
  a_state_reserved: assert property (p_state_reserved) else $error("reserved state taken"); // R2

  property p_ctx_pulse;
    @(posedge pclk) disable iff (!presetn)
      s_pm_write ##0 (power_state_field == pm_msi_pkg::power_d3hot && !context_keep_flag &&
        pwdata[1:0] == pm_msi_pkg::power_d0) |=> context_reset;
  endproperty
  a_ctx_pulse: assert property (p_ctx_pulse) else $error("context reset missing"); // R3

  property p_ctx_cause;
    @(posedge pclk) disable iff (!presetn)
      context_reset |-> !$past(context_keep_flag) &&
        power_state_field == pm_msi_pkg::power_d0;
  endproperty
  a_ctx_cause: assert property (p_ctx_cause) else $error("context reset unexpected"); // R3

  property p_pm_read_zero;
    @(posedge pclk) disable iff (!presetn)
      s_pm_read |=> prdata[7:4] == 4'h0 && !prdata[2] && prdata[14:9] == 6'h00 &&
        prdata[31:16] == 16'h0000;
  endproperty
  a_pm_read_zero: assert property (p_pm_read_zero) else $error("fixed zero bits set"); // R10 R11

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
      s_cap_write ##0 pwdata[pm_msi_pkg::msi_en_bit] |=> msi_enable;
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("msi enable not set"); // R13

  property p_msi_fires;
    @(posedge pclk) disable iff (!presetn)
      (msi_request && msi_enable) |=> msi_valid && msi_to_upstream;
  endproperty
  a_msi_fires: assert property (p_msi_fires) else $error("msi write missing"); // R18

  property p_msi_payload;
    @(posedge pclk) disable iff (!presetn)
      msi_valid |-> msi_write.payload[15:0] == $past(msg_payload);
  endproperty
  a_msi_payload: assert property (p_msi_payload) else $error("msi payload wrong"); // R20

  property p_wake_send;
    @(posedge pclk) disable iff (!presetn)
      (own_wake_event && !is_upstream && wake_msg_enable) |=> wake_msg_send;
  endproperty
  a_wake_send: assert property (p_wake_send) else $error("wake message missing"); // R4

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      s_pm_write ##0 (pwdata[pm_msi_pkg::wake_flag_bit] && !own_wake_event) |=>
        !wake_event_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("wake flag not cleared"); // R7

endmodule : pm_and_msi_capability_regs

// ### testbench/upstream_sink.sv
// partner model: upstream side that receives wake messages and MSI writes
`timescale 1ns/1ps
module upstream_sink (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // traffic from the port
  input wire logic wake_msg_send,
  input wire logic msi_valid,
  input wire logic msi_to_upstream,
  input wire pm_msi_pkg::msi_write_t msi_write
);
  int n_wake;
  int n_msi;
  pm_msi_pkg::msi_write_t last_msi;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_wake <= 0;
      n_msi <= 0;
      last_msi <= '0;
    end else begin
      if (wake_msg_send) n_wake <= n_wake + 1;
      if (msi_valid && msi_to_upstream) begin
        n_msi <= n_msi + 1;
        last_msi <= msi_write;
      end
    end
  end
endmodule : upstream_sink

// ### testbench/tb_top.sv
// testbench: APB master, reference model and scenarios for the PM/MSI registers
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, hot_reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, r_up, up_prdata;
  logic pready, pslverr, own_wake_event, forwarded_wake, msi_request;
  logic wake_msg_send, context_reset, msi_valid, msi_to_upstream, ex_ctx;
  logic [1:0] power_state_field;
  pm_msi_pkg::msi_write_t msi_write;
  int n_errors, n_compared, pst, keep, wen, wfl, msien, ewake, emsi;
  logic [31:0] alo, ahi, mdat;
  logic [96:0] elast;
  pm_and_msi_capability_regs uut (.pclk(pclk), .presetn(presetn), .hot_reset(hot_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .own_wake_event(own_wake_event),
    .forwarded_wake(forwarded_wake), .msi_request(msi_request),
    .wake_msg_send(wake_msg_send), .context_reset(context_reset),
    .power_state_field(power_state_field), .msi_valid(msi_valid),
    .msi_to_upstream(msi_to_upstream), .msi_write(msi_write));
  upstream_sink u_sink (.pclk(pclk), .presetn(presetn), .wake_msg_send(wake_msg_send),
    .msi_valid(msi_valid), .msi_to_upstream(msi_to_upstream), .msi_write(msi_write));
  // upstream flavour shares the bus; its wake flag must never set
  pm_and_msi_capability_regs #(.is_upstream(1'b1)) uut_up (.pclk(pclk), .presetn(presetn),
    .hot_reset(hot_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(up_prdata), .pready(), .pslverr(),
    .own_wake_event(own_wake_event), .forwarded_wake(forwarded_wake),
    .msi_request(msi_request), .wake_msg_send(), .context_reset(), .power_state_field(),
    .msi_valid(), .msi_to_upstream(), .msi_write());
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  task final_report;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [96:0] e, input logic [96:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  function automatic logic [31:0] ev(input logic [11:0] a);
    case (a)
      12'h0c4: ev = pst | keep << 3 | wen << 8 | wfl << 15;
      12'h0d0: ev = 32'h0080_0005 | msien << 16;
      12'h0d4: ev = alo;
      12'h0d8: ev = ahi;
      12'h0dc: ev = mdat;
      default: ev = 0;
    endcase
  endfunction : ev
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    r_up = up_prdata;
    chk("pslverr", (a[11:4] == 8'h0c && a[3:0] != 4'h4) || (a > 12'h0dc || a < 12'h0c4) ||
      (a[1:0] != 0) || (a > 12'h0c4 && a < 12'h0d0), pslverr);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    chk("read", ev(a), r);
    chk("upstream read", ev(a) & ~(a == 12'h0c4 ? 32'h0000_8000 : 32'h0), r_up);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    ex_ctx = 0;
    case (a)
      12'h0c4: begin
        ex_ctx = pst == 3 && d[1:0] == 0 && keep == 0;
        if (d[1:0] == 0 || d[1:0] == 3) pst = d[1:0];
        keep = d[3];
        wen = d[8];
        if (d[15]) wfl = 0;
      end
      12'h0d0: msien = d[16];
      12'h0d4: alo = d & 32'hffff_fffc;
      12'h0d8: ahi = d;
      12'h0dc: mdat = d & 32'h0000_ffff;
      default: ;
    endcase
    #1 chk("context_reset", ex_ctx, context_reset);
    chk("power_state_field", pst, power_state_field);
    rd(a);
  endtask : wr
  task automatic pulse(input int k);
    @(posedge pclk);
    own_wake_event <= k == 0;
    forwarded_wake <= k == 1;
    msi_request <= k == 2;
    hot_reset <= k == 3;
    @(posedge pclk);
    {own_wake_event, forwarded_wake, msi_request, hot_reset} <= 4'h0;
    repeat (3) @(posedge pclk);
    if (k == 0) begin
      ewake += wen;
      wfl = 1;
    end
    if (k == 1) ewake++;
    if (k == 2 && msien) begin
      emsi++;
      elast = {ahi != 0, ahi, alo, mdat};
    end
    if (k == 3) {pst, keep, msien, alo, ahi, mdat} = {32'd0, 32'd1, 32'd0, 96'h0};
    chk("wake count", ewake, u_sink.n_wake);
    chk("msi count", emsi, u_sink.n_msi);
    chk("msi write", elast, u_sink.last_msi);
  endtask : pulse
  task automatic rd_all;
    for (int i = 0; i < 5; i++) rd(12'(12'h0c4 + (i == 0 ? 0 : 8 + 4 * i)));
  endtask : rd_all
  initial begin
    {presetn, hot_reset, psel, penable, pwrite, paddr, pwdata} = '0;
    {own_wake_event, forwarded_wake, msi_request} = 3'h0;
    {n_errors, n_compared, pst, wen, wfl, msien, ewake, emsi} = '0;
    {keep, alo, ahi, mdat, elast} = {32'd1, 96'h0, 97'h0};
    void'($urandom(11));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd_all();
    rd(12'h0e0);
    for (int c = 0; c < 4; c++) wr(12'h0c4, ($urandom & 32'hffff_7ff4) | c);
    wr(12'h0d0, 32'hffff_ffff);
    wr(12'h0d4, $urandom);
    wr(12'h0dc, $urandom);
    for (int i = 0; i < 4; i++) begin
      wr(12'h0d8, i[0] ? $urandom | 32'h1 : 32'h0);
      wr(12'h0d0, i < 3 ? 32'h0001_0000 : 32'h0);
      pulse(2);
    end
    wr(12'h0c4, 32'h0);
    pulse(1);
    rd(12'h0c4);
    pulse(0);
    rd(12'h0c4);
    wr(12'h0c4, 32'h0000_0100);
    pulse(0);
    wr(12'h0c4, 32'h0000_8103);
    wr(12'h0c4, 32'h0000_0100);
    wr(12'h0c4, 32'h0000_010b);
    wr(12'h0c4, 32'h0000_0108);
    pulse(0);
    wr(12'h0d0, 32'h0001_0000);
    pulse(3);
    rd_all();
    // cold reset in mid-run clears the sticky wake bits as well
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    {pst, keep, wen, wfl, msien, ewake, emsi} = {32'd0, 32'd1, 160'h0};
    {alo, ahi, mdat, elast} = '0;
    rd_all();
    pulse(0);
    rd(12'h0c4);
    final_report();
  end
  initial begin
    #40000;
    n_errors++;
    final_report();
  end
endmodule : tb_top
